// >>> rtl/ifeb_pkg.sv
`default_nettype none
package ifeb_pkg;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned NUM_EN = 4;
   localparam int unsigned NUM_FLAG = 3;
   localparam int unsigned PRI_W = 3;

   // Register indices on the plain register port
   localparam logic [3:0] OFS_FLAG = 4'h0;
   localparam logic [3:0] OFS_EN0 = 4'h1;
   localparam logic [3:0] OFS_EN1 = 4'h2;
   localparam logic [3:0] OFS_EN2 = 4'h3;
   localparam logic [3:0] OFS_EN3 = 4'h4;
   localparam logic [3:0] OFS_FLAG_MASK = 4'h5;
   localparam logic [3:0] OFS_FLAG_PRI = 4'h6;

   // Flag status register fields
   localparam int unsigned checksum_gen_req_flag = 3;
   localparam int unsigned serial2_error_req_flag = 2;
   localparam int unsigned serial1_error_req_flag = 1;

   // Enable register 0 fields
   localparam int unsigned adc_done_req_en = 13;
   localparam int unsigned serial1_tx_req_en = 12;
   localparam int unsigned serial1_rx_req_en = 11;
   localparam int unsigned spi_port1_done_req_en = 10;
   localparam int unsigned spi_port1_fault_req_en = 9;
   localparam int unsigned timer_three_req_en = 8;
   localparam int unsigned timer_two_req_en = 7;
   localparam int unsigned compare_ch2_req_en = 6;
   localparam int unsigned capture_ch2_req_en = 5;
   localparam int unsigned timer_one_req_en = 3;
   localparam int unsigned compare_ch1_req_en = 2;
   localparam int unsigned capture_ch1_req_en = 1;
   localparam int unsigned ext_pin0_req_en = 0;

   // Enable register 1 fields
   localparam int unsigned serial2_tx_req_en = 15;
   localparam int unsigned serial2_rx_req_en = 14;
   localparam int unsigned ext_pin2_req_en = 13;
   localparam int unsigned timer_five_req_en = 12;
   localparam int unsigned timer_four_req_en = 11;
   localparam int unsigned compare_ch4_req_en = 10;
   localparam int unsigned compare_ch3_req_en = 9;
   localparam int unsigned ext_pin1_req_en = 4;
   localparam int unsigned pin_change_req_en = 3;
   localparam int unsigned comparator_req_en = 2;
   localparam int unsigned i2c_port1_master_req_en = 1;
   localparam int unsigned i2c_port1_slave_req_en = 0;

   // Enable register 2 fields
   localparam int unsigned parallel_port_req_en = 13;
   localparam int unsigned compare_ch5_req_en = 9;
   localparam int unsigned capture_ch5_req_en = 7;
   localparam int unsigned capture_ch4_req_en = 6;
   localparam int unsigned capture_ch3_req_en = 5;
   localparam int unsigned spi_port2_event_req_en = 1;
   localparam int unsigned spi_port2_fault_req_en = 0;

   // Enable register 3 fields
   localparam int unsigned calendar_clock_req_en = 14;
   localparam int unsigned ext_pin4_req_en = 6;
   localparam int unsigned ext_pin3_req_en = 5;
   localparam int unsigned i2c_port2_master_req_en = 2;
   localparam int unsigned i2c_port2_slave_req_en = 1;

   // Priority register: one 3-bit field per flag, at 4*(flag bit - 1)
   localparam int unsigned PRI_FIELD_STRIDE = 4;

   // Implemented-bit masks, all but PRI_IMPL built from the field positions
   localparam logic [15:0] FLAG_IMPL = 16'((1 << checksum_gen_req_flag) | (1 << serial2_error_req_flag)
      | (1 << serial1_error_req_flag));
   localparam logic [15:0] EN0_IMPL = 16'((1 << adc_done_req_en) | (1 << serial1_tx_req_en)
      | (1 << serial1_rx_req_en) | (1 << spi_port1_done_req_en) | (1 << spi_port1_fault_req_en)
      | (1 << timer_three_req_en) | (1 << timer_two_req_en) | (1 << compare_ch2_req_en)
      | (1 << capture_ch2_req_en) | (1 << timer_one_req_en) | (1 << compare_ch1_req_en)
      | (1 << capture_ch1_req_en) | (1 << ext_pin0_req_en));
   localparam logic [15:0] EN1_IMPL = 16'((1 << serial2_tx_req_en) | (1 << serial2_rx_req_en)
      | (1 << ext_pin2_req_en) | (1 << timer_five_req_en) | (1 << timer_four_req_en)
      | (1 << compare_ch4_req_en) | (1 << compare_ch3_req_en) | (1 << ext_pin1_req_en)
      | (1 << pin_change_req_en) | (1 << comparator_req_en) | (1 << i2c_port1_master_req_en)
      | (1 << i2c_port1_slave_req_en));
   localparam logic [15:0] EN2_IMPL = 16'((1 << parallel_port_req_en) | (1 << compare_ch5_req_en)
      | (1 << capture_ch5_req_en) | (1 << capture_ch4_req_en) | (1 << capture_ch3_req_en)
      | (1 << spi_port2_event_req_en) | (1 << spi_port2_fault_req_en));
   localparam logic [15:0] EN3_IMPL = 16'((1 << calendar_clock_req_en) | (1 << ext_pin4_req_en)
      | (1 << ext_pin3_req_en) | (1 << i2c_port2_master_req_en) | (1 << i2c_port2_slave_req_en));
   localparam logic [15:0] PRI_IMPL = 16'h0777;

   // Reset values
   localparam logic [15:0] FLAG_RST = 16'h0000;
   localparam logic [15:0] EN_RST = 16'h0000;
   localparam logic [15:0] PRI_RST = 16'h0000;
   localparam logic [2:0] PRI_OFF = 3'h0;
endpackage : ifeb_pkg
`default_nettype wire

// >>> rtl/ifeb_top.sv
// Behaviour
// - Unimplemented bits read zero; writes to them do nothing.
// - Flag register keeps only bits 3..1; others unimplemented.
// - Bit 3 flag set by checksum generator request.
// - Bit 2 second serial error flag, bit 1 first serial error flag.
// - Flag reads one once its request occurred, else zero.
// - Enable bit one passes its source request, zero blocks it.
// - Implemented flag and enable bits are read/write, zero after reset.
// - Enable 0 bits 13..8 map ADC, serial1 tx/rx, SPI1, timer3.
// - Enable 0 bits 7..0 map timers, compare, capture, pin0; bit 4 empty.
// - Enable 1 bits 15..9 map serial2, pin2, timers, compare 4/3.
// - Enable 1 bits 4..0 map pin1, change, comparator, I2C1; 8..5 empty.
// - Enable 2 maps parallel port, compare5, captures 5..3, SPI2.
// - Enable 3 maps calendar, pins 4/3, I2C2 master and slave.
// - Three-bit priority per flag; zero disables, seven highest.
`default_nettype none
module ifeb_top
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,

   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,

   // Flag events, one-cycle pulses on clk
   input wire logic checksum_gen_evt,
   input wire logic serial2_error_evt,
   input wire logic serial1_error_evt,

   // Raw requests of the enable-gated sources
   input wire logic [15:0] src_req_0,
   input wire logic [15:0] src_req_1,
   input wire logic [15:0] src_req_2,
   input wire logic [15:0] src_req_3,

   // Gated requests toward the CPU
   output logic [15:0] fwd_req_0,
   output logic [15:0] fwd_req_1,
   output logic [15:0] fwd_req_2,
   output logic [15:0] fwd_req_3,

   // Flag sources toward the CPU
   output logic [2:0] flag_fwd_level,
   output logic irq
);

   // Register indices on the port:
   //   0 flag status, bits 3..1 live, the rest read zero
   //   1 enable register 0
   //   2 enable register 1
   //   3 enable register 2
   //   4 enable register 3
   //   5 flag forward mask, same layout as the flag status
   //   6 flag priorities, three bits per flag, one field every four bits:
   //       bits 2..0 first serial error, 6..4 second serial error,
   //       10..8 checksum generator; the other bits read zero
   //   7..15 unmapped, writes ignored, reads zero
   //
   // Timing:
   //   a write lands at the edge that samples its strobe
   //   a read right after a write returns the new value
   //   read data stand only in the cycle after the strobe, zero otherwise
   //   an event sets its flag at the next edge
   //   irq and level follow the flag one edge later
   //   fwd_req follows src_req in the same cycle, no flop in between
   //
   // Hazards:
   //   an event and a clearing write in one cycle leave the flag set
   //   writing one to a flag sets it, as if its source had fired
   //   an event held high keeps setting its flag every cycle
   //   an unmapped index never disturbs a mapped register
   //   events come from logic on clk, so they pass no synchroniser
   //
   // Priority resets to off, so no flag reaches the core until
   // software gives it a level; enables also reset to zero and need a write.
   // Enable-gated requests are not ranked here; the vector logic
   // downstream ranks them, which keeps this bank small.

   // Flag status state
   logic [15:0] flag_q;
   logic [15:0] flag_d;
   logic [15:0] flag_evt;
   logic [15:0] flag_live;
   logic [ifeb_pkg::NUM_FLAG-1:0] evt_in;

   // Flag forwarding controls
   logic [15:0] flag_mask_q;
   logic [15:0] pri_q;
   logic [2:0] pri_flag [ifeb_pkg::NUM_FLAG];
   logic [ifeb_pkg::NUM_FLAG-1:0] pri_on;
   logic [ifeb_pkg::NUM_FLAG-1:0] flag_ready;
   logic [2:0] lvl_cand [ifeb_pkg::NUM_FLAG];
   logic [2:0] level_d;

   // Enable registers and request paths
   logic [15:0] en_q [ifeb_pkg::NUM_EN];
   logic [15:0] src_req [ifeb_pkg::NUM_EN];
   logic [15:0] fwd_req [ifeb_pkg::NUM_EN];

   // Register port decode and read path
   logic wr_flag;
   logic wr_mask;
   logic wr_pri;
   logic [ifeb_pkg::NUM_EN-1:0] wr_en;
   logic [15:0] rdata_d;

   function automatic logic [15:0] en_impl(input int unsigned idx);
      unique case (idx)
         0: en_impl = ifeb_pkg::EN0_IMPL;
         1: en_impl = ifeb_pkg::EN1_IMPL;
         2: en_impl = ifeb_pkg::EN2_IMPL;
         default: en_impl = ifeb_pkg::EN3_IMPL;
      endcase
   endfunction

   function automatic logic [3:0] en_ofs(input int unsigned idx);
      unique case (idx)
         0: en_ofs = ifeb_pkg::OFS_EN0;
         1: en_ofs = ifeb_pkg::OFS_EN1;
         2: en_ofs = ifeb_pkg::OFS_EN2;
         default: en_ofs = ifeb_pkg::OFS_EN3;
      endcase
   endfunction

   // Flag index to its bit in the flag status register
   function automatic int unsigned flag_pos(input int unsigned f);
      unique case (f)
         0: flag_pos = ifeb_pkg::serial1_error_req_flag;
         1: flag_pos = ifeb_pkg::serial2_error_req_flag;
         default: flag_pos = ifeb_pkg::checksum_gen_req_flag;
      endcase
   endfunction

   // Every input is an argument, so the assigns below re-evaluate
   function automatic logic wr_hit(input logic wr, input logic [3:0] addr, input logic [3:0] ofs);
      wr_hit = wr && (addr == ofs);
   endfunction

   // Per-register write strobes
   assign wr_flag = wr_hit(reg_wr, reg_addr, ifeb_pkg::OFS_FLAG);
   assign wr_mask = wr_hit(reg_wr, reg_addr, ifeb_pkg::OFS_FLAG_MASK);
   assign wr_pri = wr_hit(reg_wr, reg_addr, ifeb_pkg::OFS_FLAG_PRI);

   // One write strobe per enable register
   generate
      for (genvar w = 0; w < ifeb_pkg::NUM_EN; w++)
      begin : g_wr_en
         assign wr_en[w] = wr_hit(reg_wr, reg_addr, en_ofs(w));
      end
   endgenerate

   // Priority field per flag; flag f owns field f
   generate
      for (genvar f = 0; f < ifeb_pkg::NUM_FLAG; f++)
      begin : g_pri
         assign pri_flag[f] = pri_q[f * ifeb_pkg::PRI_FIELD_STRIDE +: ifeb_pkg::PRI_W];
         assign pri_on[f] = pri_flag[f] != ifeb_pkg::PRI_OFF;
      end
   endgenerate

   assign src_req[0] = src_req_0;
   assign src_req[1] = src_req_1;
   assign src_req[2] = src_req_2;
   assign src_req[3] = src_req_3;

   assign fwd_req_0 = fwd_req[0];
   assign fwd_req_1 = fwd_req[1];
   assign fwd_req_2 = fwd_req[2];
   assign fwd_req_3 = fwd_req[3];

   assign evt_in = {checksum_gen_evt, serial2_error_evt, serial1_error_evt};

   always_comb
   begin
      flag_evt = 16'h0000;
      for (int f = 0; f < ifeb_pkg::NUM_FLAG; f++)
      begin
         flag_evt[flag_pos(f)] = evt_in[f];
      end
   end

   always_comb
   begin
      flag_d = flag_q;
      // software write of one or zero
      if (wr_flag)
      begin
         flag_d = reg_wdata;
      end
      // event set has the last word
      flag_d = flag_d | flag_evt;
      flag_d = flag_d & ifeb_pkg::FLAG_IMPL;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         flag_q <= ifeb_pkg::FLAG_RST;
      end
      else
      begin
         flag_q <= flag_d;
      end
   end

   // Layouts, one source per bit, empty bits have no effect:
   //   0: 13 adc, 12 serial1 tx, 11 serial1 rx, 10 spi1 done, 9 spi1 fault,
   //      8 timer3, 7 timer2, 6 cmp2, 5 cap2, 3 timer1, 2 cmp1, 1 cap1, 0 pin0
   //   1: 15 serial2 tx, 14 serial2 rx, 13 pin2, 12 timer5, 11 timer4,
   //      10 cmp4, 9 cmp3, 4 pin1, 3 change, 2 comparator, 1/0 i2c1 master/slave
   //   2: 13 parallel port, 9 cmp5, 7..5 cap5..cap3, 1 spi2 event, 0 spi2 fault
   //   3: 14 calendar, 6 pin4, 5 pin3, 2/1 i2c2 master/slave
   // Enable writes keep only implemented positions
   // enable layouts
   generate
      for (genvar g = 0; g < ifeb_pkg::NUM_EN; g++)
      begin : g_en
         always_ff @(posedge clk)
         begin
            if (rst)
            begin
               en_q[g] <= ifeb_pkg::EN_RST;
            end
            else if (wr_en[g])
            begin
               en_q[g] <= reg_wdata & en_impl(g);
            end
         end
         assign fwd_req[g] = src_req[g] & en_q[g];
      end
   endgenerate

   // Forward mask for the flags, same layout
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         flag_mask_q <= ifeb_pkg::EN_RST;
      end
      else if (wr_mask)
      begin
         flag_mask_q <= reg_wdata & ifeb_pkg::FLAG_IMPL;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pri_q <= ifeb_pkg::PRI_RST;
      end
      else if (wr_pri)
      begin
         pri_q <= reg_wdata & ifeb_pkg::PRI_IMPL;
      end
   end

   generate
      for (genvar f = 0; f < ifeb_pkg::NUM_FLAG; f++)
      begin : g_ready
         assign flag_ready[f] = flag_q[flag_pos(f)] & flag_mask_q[flag_pos(f)] & pri_on[f];
         assign lvl_cand[f] = flag_ready[f] ? pri_flag[f] : ifeb_pkg::PRI_OFF;
      end
   endgenerate

   // Highest live level; ties need no order since only the level leaves
   always_comb
   begin
      level_d = ifeb_pkg::PRI_OFF;
      for (int i = 0; i < ifeb_pkg::NUM_FLAG; i++)
      begin
         if (lvl_cand[i] > level_d)
         begin
            level_d = lvl_cand[i];
         end
      end
   end

   // Flags that are forwarded, at their own bit positions
   always_comb
   begin
      flag_live = 16'h0000;
      for (int i = 0; i < ifeb_pkg::NUM_FLAG; i++)
      begin
         flag_live[flag_pos(i)] = flag_ready[i];
      end
   end

   // Registered so the level never glitches toward the core
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         flag_fwd_level <= ifeb_pkg::PRI_OFF;
      end
      else
      begin
         flag_fwd_level <= level_d;
      end
   end

   // Same latency as the level, so the two always agree
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         irq <= 1'b0;
      end
      else
      begin
         irq <= |flag_live;
      end
   end

   // Read mux is combinational; only the flop behind it leaves
   // unmapped and reserved read zero
   always_comb
   begin
      rdata_d = 16'h0000;
      unique case (reg_addr)
         ifeb_pkg::OFS_FLAG: rdata_d = flag_q;
         ifeb_pkg::OFS_EN0: rdata_d = en_q[0];
         ifeb_pkg::OFS_EN1: rdata_d = en_q[1];
         ifeb_pkg::OFS_EN2: rdata_d = en_q[2];
         ifeb_pkg::OFS_EN3: rdata_d = en_q[3];
         ifeb_pkg::OFS_FLAG_MASK: rdata_d = flag_mask_q;
         ifeb_pkg::OFS_FLAG_PRI: rdata_d = pri_q;
         default: rdata_d = 16'h0000;
      endcase
   end

   // Read data holds only in the cycle after the strobe
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         reg_rdata <= 16'h0000;
      end
      else if (reg_rd)
      begin
         reg_rdata <= rdata_d;
      end
      else
      begin
         reg_rdata <= 16'h0000;
      end
   end

endmodule // ifeb_top
`default_nettype wire

// >>> dv/ifeb_assertions.sv
`default_nettype none
module ifeb_assertions
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   // Raw and gated requests
   input wire logic [15:0] src_req_0,
   input wire logic [15:0] src_req_1,
   input wire logic [15:0] src_req_2,
   input wire logic [15:0] src_req_3,
   input wire logic [15:0] fwd_req_0,
   input wire logic [15:0] fwd_req_1,
   input wire logic [15:0] fwd_req_2,
   input wire logic [15:0] fwd_req_3,
   // Flag forwarding
   input wire logic [2:0] flag_fwd_level,
   input wire logic irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_gate_req_0: assert property ((fwd_req_0 & ~(src_req_0 & 16'h3fef)) == 16'h0000)
      else $error("fwd_req_0 outside request or map");
   a_gate_req_1: assert property ((fwd_req_1 & ~(src_req_1 & 16'hfe1f)) == 16'h0000)
      else $error("fwd_req_1 outside request or map");
   a_gate_req_2: assert property ((fwd_req_2 & ~(src_req_2 & 16'h22e3)) == 16'h0000)
      else $error("fwd_req_2 outside request or map");
   a_gate_req_3: assert property ((fwd_req_3 & ~(src_req_3 & 16'h4066)) == 16'h0000)
      else $error("fwd_req_3 outside request or map");
   a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data not zero outside read answer");
   a_flag_read_impl: assert property (reg_rd && reg_addr == 4'h0 |=> (reg_rdata & 16'hfff1) == 16'h0000)
      else $error("flag read shows empty bits");
   a_en3_read_impl: assert property (reg_rd && reg_addr == 4'h4 |=> (reg_rdata & 16'hbf99) == 16'h0000)
      else $error("enable 3 read shows empty bits");
   a_unmapped_read: assert property (reg_rd && reg_addr > 4'h6 |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   a_irq_level_tie: assert property (irq == (flag_fwd_level != 3'h0))
      else $error("irq and level disagree");
endmodule // ifeb_assertions
bind ifeb_top ifeb_assertions i_ifeb_assertions (.clk, .rst, .reg_addr, .reg_rd, .reg_rdata,
   .src_req_0, .src_req_1, .src_req_2, .src_req_3, .fwd_req_0, .fwd_req_1, .fwd_req_2, .fwd_req_3,
   .flag_fwd_level, .irq);
`default_nettype wire

// >>> dv/ifeb_src_model.sv
`default_nettype none
module ifeb_src_model
(
   // Clock and bench commands
   input wire logic clk,
   input wire logic [2:0] evt_cmd,
   input wire logic [15:0] req_pat,
   // Toward the block
   output logic checksum_gen_evt,
   output logic serial2_error_evt,
   output logic serial1_error_evt,
   output logic [15:0] src_req_0,
   output logic [15:0] src_req_1,
   output logic [15:0] src_req_2,
   output logic [15:0] src_req_3
);
   timeunit 1ns;
   timeprecision 1ps;
   // Peripherals launch events and levels just after an edge
   always_ff @(posedge clk)
   begin
      {checksum_gen_evt, serial2_error_evt, serial1_error_evt} <= evt_cmd;
      src_req_0 <= req_pat;
      src_req_1 <= req_pat;
      src_req_2 <= req_pat;
      src_req_3 <= req_pat;
   end
endmodule // ifeb_src_model
`default_nettype wire

// >>> dv/tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [2:0] evt_cmd = 3'h0;
   logic [15:0] req_pat = 16'h0000;
   logic checksum_gen_evt, serial2_error_evt, serial1_error_evt, irq;
   logic [15:0] reg_rdata, src_req_0, src_req_1, src_req_2, src_req_3;
   logic [15:0] fwd_req_0, fwd_req_1, fwd_req_2, fwd_req_3;
   logic [2:0] flag_fwd_level;
   int mismatches = 0;
   int check_count = 0;
   int cycles = 0;
   logic [15:0] impl [5] = '{16'h000e, 16'h3fef, 16'hfe1f, 16'h22e3, 16'h4066};
   ifeb_src_model i_ifeb_src_model (.clk, .evt_cmd, .req_pat, .checksum_gen_evt, .serial2_error_evt,
      .serial1_error_evt, .src_req_0, .src_req_1, .src_req_2, .src_req_3);
   ifeb_top i_ifeb_top (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .checksum_gen_evt,
      .serial2_error_evt, .serial1_error_evt, .src_req_0, .src_req_1, .src_req_2, .src_req_3,
      .fwd_req_0, .fwd_req_1, .fwd_req_2, .fwd_req_3, .flag_fwd_level, .irq);
   always #12.5 clk = ~clk;
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask
   // Event pulse, then room for flag and registered irq
   task automatic fire(input logic [2:0] e);
      @(posedge clk);
      evt_cmd <= e;
      @(posedge clk);
      evt_cmd <= 3'h0;
      repeat (4) @(posedge clk);
      #1;
   endtask
   task automatic settle;
      repeat (3) @(posedge clk);
      #1;
   endtask
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         mismatches++;
         give_verdict();
      end
   end
   initial
   begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      for (int a = 0; a < 16; a++)
         rdc(4'(a), 16'h0000);
      $display("reset values done");
      for (int a = 0; a < 5; a++)
      begin
         wr(4'(a), 16'hffff);
         rdc(4'(a), impl[a]);
      end
      wr(4'h9, 16'hffff);
      rdc(4'h9, 16'h0000);
      $display("register map done");
      @(posedge clk);
      req_pat <= 16'hffff;
      settle();
      chk(fwd_req_0, impl[1]);
      chk(fwd_req_1, impl[2]);
      chk(fwd_req_2, impl[3]);
      chk(fwd_req_3, impl[4]);
      wr(4'h1, 16'h0000);
      settle();
      chk(fwd_req_0, 16'h0000);
      $display("gating done");
      wr(4'h0, 16'h0000);
      rdc(4'h0, 16'h0000);
      wr(4'h5, 16'hffff);
      wr(4'h6, 16'h0701);
      fire(3'b001);
      chk({15'h0, irq}, 16'h0001);
      chk({13'h0, flag_fwd_level}, 16'h0001);
      rdc(4'h0, 16'h0002);
      fire(3'b100);
      chk({13'h0, flag_fwd_level}, 16'h0007);
      rdc(4'h0, 16'h000a);
      wr(4'h0, 16'h0002);
      rdc(4'h0, 16'h0002);
      settle();
      chk({13'h0, flag_fwd_level}, 16'h0001);
      wr(4'h5, 16'h0000);
      settle();
      chk({15'h0, irq}, 16'h0000);
      wr(4'h5, 16'hffff);
      wr(4'h6, 16'h0700);
      fire(3'b010);
      chk({15'h0, irq}, 16'h0000);
      rdc(4'h0, 16'h0006);
      $display("flags done");
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rdc(4'h2, 16'h0000);
      chk({15'h0, irq}, 16'h0000);
      $display("second reset done");
      give_verdict();
   end
endmodule // tb
`default_nettype wire
